// file: design/pll_ratio_source_select.sv
// Ratio slots, ratio selection, scaling, format and fractional-N source selection
//
// Overview of operation
// - Four 32-bit unsigned fixed-point ratio slots hold wanted output/input ratios.
// - Static mode uses the slot chosen by static_ratio_select.
// - High-resolution format: 12 integer bits, 20 fraction bits.
// - Reference divider is compensated inside; software writes the plain ratio.
// - Dynamic mode uses the slot chosen by dynamic_ratio_select.
// - High-multiplication format: 20 integer bits, 12 fraction bits.
// - Format setting resets to the 20.12 interpretation.
// - 20.12 only when format bit clear and dynamic source chosen; else 12.20.
// - Automatic mode without sync clock forces 12.20 regardless of format bit.
// - Scaling works on an internal copy; stored slots never change.
// - Scale code resets to 000; codes give 1,2,4,8,1/2,1/4,1/8,1/16.
// - Effective ratio is always active ratio times scale factor.
// - Fractional-N value comes from effective ratio or digital PLL output.
// - Manual selection: pointers equal, source from fraction_source_select.
// - Automatic selection is on exactly when the two pointers differ.
// - Automatic: dynamic source with sync clock present, static when absent.
// - After sync loss wait 2^23 reference cycles before going static.
// - Automatic selection ignores fraction_source_select.
// - Mode change causes no runt period on the synthesized clock.
// - Any write affecting the fractional-N value forces the PLL unlocked.
`timescale 1ns/10ps
module pll_ratio_source_select #(
   parameter int LOSS_WAIT_CYCLES = 2 ** ratio_pkg::LOSS_WAIT_LOG2
) (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   output logic      [7:0]  REG_RDATA,
   input  wire logic        SYNC_CLK_PRESENT,
   input  wire logic [31:0] DPLL_FRACTION,
   input  wire logic        SYNTH_PERIOD_END,
   output logic      [31:0] EFFECTIVE_RATIO,
   output logic      [31:0] FRACTION_VALUE,
   output logic             FRACTION_IS_DYNAMIC,
   output logic             FORMAT_HIGH_MULT,
   output logic             FORCE_UNLOCK
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]  config_one_q, config_one_d;
   logic [7:0]  config_two_q, config_two_d;
   logic [31:0] slot_q [ratio_pkg::SLOT_COUNT];
   logic [31:0] slot_d [ratio_pkg::SLOT_COUNT];
   logic [7:0]  rdata_q, rdata_d;
   logic        unlock_q, unlock_d;

   // ----------------------------------------------------------------
   // Decoded fields
   // ----------------------------------------------------------------
   // Field values and slot byte addressing
   logic [1:0] static_ratio_select;
   logic [1:0] dynamic_ratio_select;
   logic [2:0] ratio_scale_select;
   logic       fraction_source_select;
   logic       ratio_format_select;
   logic       auto_select;
   logic       slot_hit;
   logic [7:0] slot_offset;
   logic [1:0] slot_index;
   logic [1:0] byte_index;

   // Fields picked out of the two configuration registers
   assign static_ratio_select    = config_one_q[ratio_pkg::STATIC_SEL_LSB +: 2];
   assign ratio_scale_select     = config_one_q[ratio_pkg::SCALE_SEL_LSB +: 3];
   assign dynamic_ratio_select   = config_two_q[ratio_pkg::DYNAMIC_SEL_LSB +: 2];
   assign fraction_source_select = config_two_q[ratio_pkg::FRAC_SRC_BIT];
   assign ratio_format_select    = config_two_q[ratio_pkg::FORMAT_BIT];

   // Pointers that differ turn automatic selection on
   assign auto_select = (dynamic_ratio_select != static_ratio_select);

   // Slot byte addressing, most significant byte at the lowest address
   assign slot_hit    = (REG_ADDR >= ratio_pkg::ADDR_SLOT_BASE) &&
                        (REG_ADDR <= ratio_pkg::ADDR_SLOT_LAST);
   assign slot_offset = REG_ADDR - ratio_pkg::ADDR_SLOT_BASE;
   assign slot_index  = slot_offset[3:2];
   assign byte_index  = slot_offset[1:0];

   // ----------------------------------------------------------------
   // Sync clock input synchroniser
   // ----------------------------------------------------------------
   // First and second synchroniser stages
   logic sync_meta_q, sync_meta_d;
   logic sync_seen_q, sync_seen_d;

   // Two flops in a row before anything reads the sync presence
   always_comb begin
      sync_meta_d = SYNC_CLK_PRESENT;
      sync_seen_d = sync_meta_q;
   end

   // Synchroniser registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         sync_meta_q <= 1'b0;
         sync_seen_q <= 1'b0;
      end else begin
         sync_meta_q <= sync_meta_d;
         sync_seen_q <= sync_seen_d;
      end
   end

   // ----------------------------------------------------------------
   // Register write and read
   // ----------------------------------------------------------------
   // Writes to any ratio-affecting field raise a one-cycle unlock pulse
   always_comb begin
      config_one_d = config_one_q;
      config_two_d = config_two_q;
      for (int i = 0; i < ratio_pkg::SLOT_COUNT; i++) begin
         slot_d[i] = slot_q[i];
      end
      rdata_d  = rdata_q;
      // Unlock pulse lasts one cycle per accepted write
      unlock_d = 1'b0;
      // Writes land in the addressed register or slot byte
      if (REG_WR) begin
         if (REG_ADDR == ratio_pkg::ADDR_CONFIG_ONE) begin
            config_one_d = REG_WDATA;
            unlock_d     = 1'b1;
         end else if (REG_ADDR == ratio_pkg::ADDR_CONFIG_TWO) begin
            config_two_d = REG_WDATA;
            unlock_d     = 1'b1;
         end else if (slot_hit) begin
            slot_d[slot_index][8 * (3 - byte_index) +: 8] = REG_WDATA;
            unlock_d = 1'b1;
         end
      end
      // Reads of unmapped addresses return zero
      if (REG_RD) begin
         if (REG_ADDR == ratio_pkg::ADDR_CONFIG_ONE) begin
            rdata_d = config_one_q;
         end else if (REG_ADDR == ratio_pkg::ADDR_CONFIG_TWO) begin
            rdata_d = config_two_q;
         end else if (slot_hit) begin
            rdata_d = slot_q[slot_index][8 * (3 - byte_index) +: 8];
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   // Configuration, slot, read data and unlock registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         config_one_q <= ratio_pkg::CONFIG_ONE_RESET;
         config_two_q <= ratio_pkg::CONFIG_TWO_RESET;
         for (int i = 0; i < ratio_pkg::SLOT_COUNT; i++) begin
            slot_q[i] <= ratio_pkg::SLOT_RESET;
         end
         rdata_q  <= 8'h00;
         unlock_q <= 1'b0;
      end else begin
         config_one_q <= config_one_d;
         config_two_q <= config_two_d;
         for (int i = 0; i < ratio_pkg::SLOT_COUNT; i++) begin
            slot_q[i] <= slot_d[i];
         end
         rdata_q  <= rdata_d;
         unlock_q <= unlock_d;
      end
   end

   // ----------------------------------------------------------------
   // Sync loss timer
   // ----------------------------------------------------------------
   // Holds the dynamic choice until the sync clock has been gone long enough
   logic [ratio_pkg::LOSS_WAIT_LOG2:0] loss_count_q, loss_count_d;
   logic                               sync_held_q, sync_held_d;

   always_comb begin
      loss_count_d = loss_count_q;
      sync_held_d  = sync_held_q;
      if (sync_seen_q) begin
         loss_count_d = '0;
         sync_held_d  = 1'b1;
      end else if (sync_held_q) begin
         if (loss_count_q >= (ratio_pkg::LOSS_WAIT_LOG2 + 1)'(LOSS_WAIT_CYCLES - 1)) begin
            sync_held_d = 1'b0;
         end else begin
            loss_count_d = loss_count_q + 1'b1;
         end
      end
   end

   // Loss timer registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         loss_count_q <= '0;
         sync_held_q  <= 1'b0;
      end else begin
         loss_count_q <= loss_count_d;
         sync_held_q  <= sync_held_d;
      end
   end

   // ----------------------------------------------------------------
   // Source choice and glitch-free switch
   // ----------------------------------------------------------------
   // Wanted source and the source actually applied
   ratio_pkg::frac_src_t wanted_src;
   ratio_pkg::frac_src_t src_q, src_d;

   // Automatic mode follows the held sync presence and ignores the manual bit
   always_comb begin
      if (auto_select) begin
         wanted_src = sync_held_q ? ratio_pkg::SRC_DYNAMIC
                                  : ratio_pkg::SRC_STATIC;
      end else begin
         wanted_src = fraction_source_select ? ratio_pkg::SRC_DYNAMIC
                                             : ratio_pkg::SRC_STATIC;
      end
   end

   // Source only changes at the end of a synthesized period, avoiding runts
   always_comb begin
      src_d = src_q;
      if (SYNTH_PERIOD_END) begin
         src_d = wanted_src;
      end
   end

   // Applied source register, static after reset
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         src_q <= ratio_pkg::SRC_STATIC;
      end else begin
         src_q <= src_d;
      end
   end

   // ----------------------------------------------------------------
   // Active ratio and scaling
   // ----------------------------------------------------------------
   // Bundle between this block and the scaler
   ratio_scale_if rs ();

   // Copy of the chosen slot goes to the scaler; slots stay untouched
   assign rs.user_ratio = (src_q == ratio_pkg::SRC_DYNAMIC) ?
                          slot_q[dynamic_ratio_select] :
                          slot_q[static_ratio_select];
   assign rs.scale_code = ratio_scale_select;

   // Power-of-two scaling of the active ratio copy
   ratio_scaler u_scaler (
      .rs (rs.scaler)
   );

   // ----------------------------------------------------------------
   // Format and outputs
   // ----------------------------------------------------------------
   // Format choice and next output values
   logic        high_mult;
   logic [31:0] eff_d, frac_d;

   // 20.12 only when format bit clear and dynamic chosen; auto without sync forces 12.20
   always_comb begin
      high_mult = !ratio_format_select && (src_q == ratio_pkg::SRC_DYNAMIC);
      if (auto_select && !sync_held_q) begin
         high_mult = 1'b0;
      end
      eff_d  = rs.effective_ratio;
      frac_d = (src_q == ratio_pkg::SRC_DYNAMIC) ? DPLL_FRACTION
                                                 : rs.effective_ratio;
   end

   // Registered copies presented at the ports
   logic [31:0] eff_q, frac_q;
   logic        high_mult_q;

   // Output registers
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         eff_q       <= 32'h0000_0000;
         frac_q      <= 32'h0000_0000;
         high_mult_q <= 1'b0;
      end else begin
         eff_q       <= eff_d;
         frac_q      <= frac_d;
         high_mult_q <= high_mult;
      end
   end

   // Top-level outputs straight from registers
   assign EFFECTIVE_RATIO     = eff_q;
   assign FRACTION_VALUE      = frac_q;
   assign FRACTION_IS_DYNAMIC = (src_q == ratio_pkg::SRC_DYNAMIC);
   assign FORMAT_HIGH_MULT    = high_mult_q;
   assign FORCE_UNLOCK        = unlock_q;
   assign REG_RDATA           = rdata_q;

endmodule // pll_ratio_source_select

// file: design/ratio_pkg.sv
// Package of constants and types for the ratio and fractional-N source selection block
package ratio_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG_ONE  = 8'h03;
   localparam logic [7:0] ADDR_CONFIG_TWO  = 8'h04;
   localparam logic [7:0] ADDR_SLOT_BASE   = 8'h06;
   localparam logic [7:0] ADDR_SLOT_LAST   = 8'h15;
   localparam int         SLOT_COUNT       = 4;
   localparam int         SLOT_BYTES       = 4;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   // device_config_one
   localparam int STATIC_SEL_LSB   = 5;     // static_ratio_select [6:5]
   localparam int SCALE_SEL_LSB    = 0;     // ratio_scale_select [2:0]
   // device_config_two
   localparam int DYNAMIC_SEL_LSB  = 1;     // dynamic_ratio_select [2:1]
   localparam int FRAC_SRC_BIT     = 0;     // fraction_source_select
   localparam int FORMAT_BIT       = 3;     // ratio_format_select

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  CONFIG_ONE_RESET = 8'h00;
   localparam logic [7:0]  CONFIG_TWO_RESET = 8'h00;
   localparam logic [31:0] SLOT_RESET       = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int LOSS_WAIT_LOG2 = 23;      // Sync loss wait is 2^23 reference cycles

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic {
      SRC_STATIC,
      SRC_DYNAMIC
   } frac_src_t;

endpackage : ratio_pkg

// file: design/ratio_scale_if.sv
// Interface carrying the active ratio, scale code and scaled result
`timescale 1ns/10ps
interface ratio_scale_if;
   logic [31:0] user_ratio;
   logic [2:0]  scale_code;
   logic [31:0] effective_ratio;

   modport producer (output user_ratio, output scale_code, input effective_ratio);
   modport scaler   (input user_ratio, input scale_code, output effective_ratio);
endinterface : ratio_scale_if

// file: design/ratio_scaler.sv
// Power-of-two ratio scaler working on a copy of the active ratio
`timescale 1ns/10ps
module ratio_scaler (
   ratio_scale_if.scaler rs
);

   // ----------------------------------------------------------------
   // Scaling
   // ----------------------------------------------------------------
   // Codes 0..3 shift left, codes 4..7 shift right by 1..4
   always_comb begin
      unique case (rs.scale_code)
         3'h0: rs.effective_ratio = rs.user_ratio;
         3'h1: rs.effective_ratio = {rs.user_ratio[30:0], 1'b0};
         3'h2: rs.effective_ratio = {rs.user_ratio[29:0], 2'b0};
         3'h3: rs.effective_ratio = {rs.user_ratio[28:0], 3'b0};
         3'h4: rs.effective_ratio = {1'b0, rs.user_ratio[31:1]};
         3'h5: rs.effective_ratio = {2'b0, rs.user_ratio[31:2]};
         3'h6: rs.effective_ratio = {3'b0, rs.user_ratio[31:3]};
         3'h7: rs.effective_ratio = {4'b0, rs.user_ratio[31:4]};
      endcase
   end

endmodule // ratio_scaler

// file: test/sync_source_model.sv
// Model of the sync clock source and digital PLL facing the block
`timescale 1ns/10ps
module sync_source_model #(
   parameter logic [31:0] DPLL_VALUE = 32'h0034_5678
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sync_en,
   input  wire logic        slow,
   output logic             sync_present,
   output logic      [31:0] dpll_fraction,
   output logic             period_end
);
   logic [3:0] cnt_q;

   // Free counter paces slow period ends and the idle pattern
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   // Presence follows the bench; without sync the fraction is junk that moves
   assign sync_present  = sync_en;
   assign dpll_fraction = sync_en ? DPLL_VALUE : {8{cnt_q}};
   assign period_end    = slow ? (cnt_q[2:0] == 3'h7) : 1'b1;
endmodule // sync_source_model

// file: test/ratio_select_assertions.sv
// Port-level checker for the ratio and source selection block
`timescale 1ns/10ps
module ratio_select_assertions #(
   parameter int LOSS_WAIT_CYCLES = 16
) (
   input wire logic        CLK_SYS,
   input wire logic        RST,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_ADDR,
   input wire logic [7:0]  REG_RDATA,
   input wire logic        SYNC_CLK_PRESENT,
   input wire logic [31:0] DPLL_FRACTION,
   input wire logic        SYNTH_PERIOD_END,
   input wire logic [31:0] EFFECTIVE_RATIO,
   input wire logic [31:0] FRACTION_VALUE,
   input wire logic        FRACTION_IS_DYNAMIC,
   input wire logic        FORMAT_HIGH_MULT,
   input wire logic        FORCE_UNLOCK
);
   wire logic mapped = REG_ADDR inside {[ratio_pkg::ADDR_CONFIG_ONE:ratio_pkg::ADDR_CONFIG_TWO],
                                        [ratio_pkg::ADDR_SLOT_BASE:ratio_pkg::ADDR_SLOT_LAST]};

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   // Unlock pulse follows exactly the mapped writes
   AST_UNLOCK_ON_WRITE: assert property (REG_WR && mapped |=> FORCE_UNLOCK)
      else $error("no unlock after register write");
   AST_NO_SPURIOUS_UNLOCK: assert property (!(REG_WR && mapped) |=> !FORCE_UNLOCK)
      else $error("unlock without a mapped write");
   AST_UNMAPPED_READ_ZERO: assert property (REG_RD && !mapped |=> REG_RDATA == 8'h00)
      else $error("unmapped read not zero");
   // Fractional-N value follows the applied source
   AST_FRAC_DYNAMIC: assert property (
      FRACTION_IS_DYNAMIC [*2] ##0 $stable(DPLL_FRACTION) |-> FRACTION_VALUE == DPLL_FRACTION)
      else $error("fraction not from digital PLL");
   AST_FRAC_STATIC: assert property (
      (!FRACTION_IS_DYNAMIC) [*2] ##0 $stable(EFFECTIVE_RATIO)
      |-> FRACTION_VALUE == EFFECTIVE_RATIO)
      else $error("fraction not from effective ratio");
   AST_STATIC_FORMAT: assert property (
      (!FRACTION_IS_DYNAMIC) [*3] |-> !$past(FORMAT_HIGH_MULT))
      else $error("20.12 format with static source");
   AST_SWITCH_AT_BOUNDARY: assert property (
      $changed(FRACTION_IS_DYNAMIC) |-> $past(SYNTH_PERIOD_END))
      else $error("source switched off a period boundary");
   AST_LOSS_HOLD: assert property (
      FRACTION_IS_DYNAMIC && $fell(SYNC_CLK_PRESENT) |-> FRACTION_IS_DYNAMIC [*8])
      else $error("left dynamic source too soon after sync loss");
endmodule // ratio_select_assertions

bind pll_ratio_source_select ratio_select_assertions #(.LOSS_WAIT_CYCLES(LOSS_WAIT_CYCLES)) u_chk (
   .CLK_SYS(CLK_SYS), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
   .REG_RDATA(REG_RDATA), .SYNC_CLK_PRESENT(SYNC_CLK_PRESENT), .DPLL_FRACTION(DPLL_FRACTION),
   .SYNTH_PERIOD_END(SYNTH_PERIOD_END), .EFFECTIVE_RATIO(EFFECTIVE_RATIO),
   .FRACTION_VALUE(FRACTION_VALUE), .FRACTION_IS_DYNAMIC(FRACTION_IS_DYNAMIC),
   .FORMAT_HIGH_MULT(FORMAT_HIGH_MULT), .FORCE_UNLOCK(FORCE_UNLOCK));

// file: test/tb_top.sv
// Self-checking bench for the ratio and source selection block
`timescale 1ns/10ps
module tb_top;
   localparam logic [31:0] DPLL_VALUE = 32'h0034_5678;
   logic        clk_sys, rst, reg_wr, reg_rd, sync_en, slow, sync_present, period_end;
   logic        frac_dyn, fmt_hm, force_unlock;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [31:0] dpll_fraction, eff_ratio, frac_value;
   logic [31:0] slot_v [4];
   logic [31:0] seed = 32'h41f7;
   int          error_cnt = 0;
   int          comparisons = 0;

   pll_ratio_source_select #(.LOSS_WAIT_CYCLES(16)) i_dut (
      .CLK_SYS(clk_sys), .RST(rst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SYNC_CLK_PRESENT(sync_present),
      .DPLL_FRACTION(dpll_fraction), .SYNTH_PERIOD_END(period_end),
      .EFFECTIVE_RATIO(eff_ratio), .FRACTION_VALUE(frac_value),
      .FRACTION_IS_DYNAMIC(frac_dyn), .FORMAT_HIGH_MULT(fmt_hm), .FORCE_UNLOCK(force_unlock));

   sync_source_model #(.DPLL_VALUE(DPLL_VALUE)) i_sync (
      .clk(clk_sys), .rst(rst), .sync_en(sync_en), .slow(slow), .sync_present(sync_present),
      .dpll_fraction(dpll_fraction), .period_end(period_end));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected ratio after the power-of-two modifier
   function automatic logic [31:0] scaled(input logic [31:0] v, input logic [2:0] c);
      return c[2] ? v >> (c[1:0] + 3'd1) : v << c[1:0];
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize();
      if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1 chk("unlock", 32'(force_unlock), 32'(a inside {[8'h03:8'h04], [8'h06:8'h15]}));
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk("rdata", 32'(reg_rdata), 32'(e));
   endtask

   // Slot bytes go most significant first
   task automatic wslot(input int n, input logic [31:0] v);
      for (int b = 0; b < 4; b++) begin
         wr(8'(ratio_pkg::ADDR_SLOT_BASE + 4 * n + b), v[31 - 8 * b -: 8]);
      end
      slot_v[n] = v;
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      sync_en = 1'b0;
      slow = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      settle(1);
      chk("eff_rst", eff_ratio, 32'h0);
      chk("fmt_rst", 32'(fmt_hm), 32'h0);
      rd(ratio_pkg::ADDR_CONFIG_TWO, ratio_pkg::CONFIG_TWO_RESET);
      rd(8'h05, 8'h00);
      wr(8'h16, 8'h55);
      // Host keeps scaled ratios in range, one slot at the upper corner
      for (int n = 0; n < 4; n++) wslot(n, xs() & 32'h0fff_ffff);
      wslot(1, 32'h0fff_ffff);
      // Static selection over every pointer and scale code
      for (int s = 0; s < 4; s++) begin
         wr(8'h04, 8'(s << 1));
         for (int c = 0; c < 8; c++) begin
            wr(8'h03, 8'((s << 5) | c));
            settle(3);
            chk("eff", eff_ratio, scaled(slot_v[s], 3'(c)));
            chk("frac", frac_value, scaled(slot_v[s], 3'(c)));
         end
         rd(8'(8'h06 + 4 * s), slot_v[s][31:24]);
         rd(8'h03, 8'(8'h67 & ((s << 5) | 7)));
      end
      // Manual dynamic source in both formats
      @(posedge clk_sys);
      sync_en <= 1'b1;
      wr(8'h03, 8'h40);
      wr(8'h04, 8'h05);
      settle(6);
      chk("dyn", 32'(frac_dyn), 32'h1);
      chk("fv_dyn", frac_value, DPLL_VALUE);
      chk("fmt_hm", 32'(fmt_hm), 32'h1);
      chk("eff_dyn", eff_ratio, slot_v[2]);
      wr(8'h04, 8'h0d);
      settle(4);
      chk("fmt_hr", 32'(fmt_hm), 32'h0);
      // Automatic selection with slow period boundaries, source bit clear
      @(posedge clk_sys);
      slow <= 1'b1;
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h04);
      settle(12);
      chk("auto_dyn", 32'(frac_dyn), 32'h1);
      chk("auto_eff", eff_ratio, slot_v[2]);
      chk("auto_fmt", 32'(fmt_hm), 32'h1);
      @(posedge clk_sys);
      sync_en <= 1'b0;
      settle(18);
      chk("loss_hold", 32'(frac_dyn), 32'h1);
      settle(18);
      chk("loss_dyn", 32'(frac_dyn), 32'h0);
      chk("loss_eff", eff_ratio, slot_v[0]);
      chk("loss_fv", frac_value, slot_v[0]);
      chk("loss_fmt", 32'(fmt_hm), 32'h0);
      wr(8'h04, 8'h05);
      settle(12);
      chk("auto_ign", 32'(frac_dyn), 32'h0);
      // Equal pointers return to manual: static despite sync present
      wr(8'h04, 8'h00);
      @(posedge clk_sys);
      sync_en <= 1'b1;
      settle(12);
      chk("man_static", 32'(frac_dyn), 32'h0);
      summarize();
   end
endmodule // tb_top
